// *** logic/hvsp_pkg.sv ***
package hvsp_pkg;

  // Serial frame: one start bit, eight payload bits, two trailing bits
  localparam int FRAME_BITS = 11;
  localparam logic [3:0] FRAME_LAST = 4'(FRAME_BITS - 1);

  // Instruction codes carried on the serial instruction line
  localparam logic [7:0] INS_LOAD_CMD    = 8'h4c;
  localparam logic [7:0] INS_ADDR_LO     = 8'h0c;
  localparam logic [7:0] INS_ADDR_HI     = 8'h1c;
  localparam logic [7:0] INS_DATA_LO     = 8'h2c;
  localparam logic [7:0] INS_DATA_HI     = 8'h3c;
  localparam logic [7:0] INS_LATCH_FLASH = 8'h7d;
  localparam logic [7:0] INS_LATCH_EE    = 8'h6d;
  localparam logic [7:0] INS_PROG_A      = 8'h64;
  localparam logic [7:0] INS_PROG_B      = 8'h6c;
  localparam logic [7:0] INS_RD_LO_EN    = 8'h68;
  localparam logic [7:0] INS_RD_HI_EN    = 8'h78;

  // Command codes carried on the serial data line with INS_LOAD_CMD
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_ERASE    = 8'h80;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;

  // Entry pattern on data out pin, instruction in, data in (bit 2..0)
  localparam logic [2:0] ENTRY_PATTERN = 3'h0;
  localparam logic [7:0] LOCK_ERASED   = 8'hff;

  // Entry pattern latch point after the high voltage is seen
  localparam int SYS_CLK_NS    = 100;
  localparam int HV_LATCH_NS   = 100;
  localparam int ENTRY_HOLD_NS = 10000;
  localparam int HV_LATCH_RAW  = (HV_LATCH_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int HV_LATCH_CYCLES = (HV_LATCH_RAW < 1) ? 1 : HV_LATCH_RAW;
  localparam logic [7:0] HV_LATCH_CNT = 8'(HV_LATCH_CYCLES);

  typedef enum logic [2:0] {
    ST_OFF,
    ST_LATCH,
    ST_REJECT,
    ST_READY,
    ST_ERASE,
    ST_PROG
  } mode_t;

endpackage

// *** logic/mem_port_if.sv ***
`timescale 1ns/10ps
interface mem_port_if #(
  parameter int AW = 8,
  parameter int DW = 8
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// *** logic/nv_mem.sv ***
`timescale 1ns/10ps
module nv_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  // Clock
  input  wire logic clk_in,
  // Access port
  mem_port_if.mem   port
);

  logic [DW-1:0] mem_r [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;

  // Contents are not reset: the array stands for nonvolatile cells
  always_ff @(posedge clk_in)
  begin
    if (port.we)
    begin
      mem_r[port.waddr] <= port.wdata;
    end
    rdata_r <= mem_r[port.raddr];
  end

  assign port.rdata = rdata_r;

endmodule // nv_mem

// *** logic/hvsp_seq.sv ***
`timescale 1ns/10ps
module hvsp_seq
  import hvsp_pkg::*;
#(
  parameter int FLASH_AW = 12,
  parameter int FLASH_PW = 5,
  parameter int EE_AW    = 9,
  parameter int EE_PW    = 2
) (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Programming pins
  input  wire logic       hv_reset_in,
  input  wire logic       serial_clock_in,
  input  wire logic       serial_data_in,
  input  wire logic       serial_instr_in,
  input  wire logic       serial_data_out_in,
  output logic            serial_data_out_out,
  output logic            serial_data_out_oe_out,
  // Fuse and lock state
  input  wire logic       keep_eeprom_on_erase_in,
  input  wire logic [7:0] lock_bits_in,
  // Status
  output logic            prog_mode_out,
  output logic            busy_out,
  output logic [7:0]      lock_bits_out
);

  localparam int FPAGE = 1 << FLASH_PW;
  localparam int EPAGE = 1 << EE_PW;
  localparam logic [15:0] FLASH_LAST = 16'((1 << FLASH_AW) - 1);
  localparam logic [15:0] EE_LAST    = 16'((1 << EE_AW) - 1);
  localparam logic [15:0] FPAGE_END  = 16'(FPAGE);
  localparam logic [15:0] EPAGE_END  = 16'(EPAGE);

  typedef struct packed {
    mode_t            mode;
    logic             hv_q1;
    logic             hv_q2;
    logic             sci_q1;
    logic             sci_q2;
    logic             sci_q3;
    logic             sdi_q1;
    logic             sdi_q2;
    logic             sii_q1;
    logic             sii_q2;
    logic             sdop_q1;
    logic             sdop_q2;
    logic [7:0]       cnt;
    logic [3:0]       bit_cnt;
    logic [10:0]      sdi_sh;
    logic [10:0]      sii_sh;
    logic [10:0]      out_sh;
    logic             out_valid;
    logic [7:0]       cmd;
    logic [7:0]       prev_ins;
    logic [7:0]       addr_lo;
    logic [7:0]       addr_hi;
    logic [7:0]       data_lo;
    logic [7:0]       data_hi;
    logic [FPAGE-1:0] fmask;
    logic [EPAGE-1:0] emask;
    logic             erase_ee;
    logic             keep;
    logic [15:0]      idx;
    logic [7:0]       lock;
    logic             serial_data_out;
    logic             oe;
    logic             linked;
    logic             busy;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  mem_port_if #(.AW(FLASH_AW), .DW(16)) fl_if ();
  mem_port_if #(.AW(FLASH_PW), .DW(16)) fb_if ();
  mem_port_if #(.AW(EE_AW),    .DW(8))  ee_if ();
  mem_port_if #(.AW(EE_PW),    .DW(8))  eb_if ();

  nv_mem #(.AW(FLASH_AW), .DW(16)) u_flash (.clk_in(clk_sys_in), .port(fl_if.mem));
  nv_mem #(.AW(FLASH_PW), .DW(16)) u_fbuf  (.clk_in(clk_sys_in), .port(fb_if.mem));
  nv_mem #(.AW(EE_AW),    .DW(8))  u_ee    (.clk_in(clk_sys_in), .port(ee_if.mem));
  nv_mem #(.AW(EE_PW),    .DW(8))  u_ebuf  (.clk_in(clk_sys_in), .port(eb_if.mem));

  logic [15:0] addr_w;
  logic        sci_rise;
  logic        frame_ev;
  logic        do_dec;
  logic [10:0] sdi_frame;
  logic [10:0] sii_frame;
  logic [7:0]  ins;
  logic [7:0]  dbyte;

  assign addr_w    = {st_r.addr_hi, st_r.addr_lo};
  assign sci_rise  = st_r.sci_q2 & ~st_r.sci_q3;
  assign frame_ev  = st_r.linked && sci_rise && (st_r.bit_cnt == FRAME_LAST);
  assign do_dec    = frame_ev && (st_r.mode == ST_READY);
  assign sdi_frame = {st_r.sdi_sh[9:0], st_r.sdi_q2};
  assign sii_frame = {st_r.sii_sh[9:0], st_r.sii_q2};
  assign ins       = sii_frame[9:2];
  assign dbyte     = sdi_frame[9:2];

  always_comb
  begin
    logic [15:0] slot;
    slot = st_r.idx - 16'h0001;
    st_nxt = st_r;
    fl_if.we    = 1'b0;
    fl_if.waddr = addr_w[FLASH_AW-1:0];
    fl_if.wdata = '1;
    fl_if.raddr = addr_w[FLASH_AW-1:0];
    fb_if.we    = 1'b0;
    fb_if.waddr = st_r.addr_lo[FLASH_PW-1:0];
    fb_if.wdata = {st_r.data_hi, st_r.data_lo};
    fb_if.raddr = st_r.idx[FLASH_PW-1:0];
    ee_if.we    = 1'b0;
    ee_if.waddr = addr_w[EE_AW-1:0];
    ee_if.wdata = '1;
    ee_if.raddr = addr_w[EE_AW-1:0];
    eb_if.we    = 1'b0;
    eb_if.waddr = st_r.addr_lo[EE_PW-1:0];
    eb_if.wdata = st_r.data_lo;
    eb_if.raddr = st_r.idx[EE_PW-1:0];

    // Two-stage synchronisers for every pin
    st_nxt.hv_q1   = hv_reset_in;
    st_nxt.hv_q2   = st_r.hv_q1;
    st_nxt.sci_q1  = serial_clock_in;
    st_nxt.sci_q2  = st_r.sci_q1;
    st_nxt.sci_q3  = st_r.sci_q2;
    st_nxt.sdi_q1  = serial_data_in;
    st_nxt.sdi_q2  = st_r.sdi_q1;
    st_nxt.sii_q1  = serial_instr_in;
    st_nxt.sii_q2  = st_r.sii_q1;
    st_nxt.sdop_q1 = serial_data_out_in;
    st_nxt.sdop_q2 = st_r.sdop_q1;

    // Frame shifter; frames keep counting while busy but are not decoded
    if (st_r.linked && sci_rise)
    begin
      st_nxt.sdi_sh = sdi_frame;
      st_nxt.sii_sh = sii_frame;
      st_nxt.out_sh = {st_r.out_sh[9:0], 1'b0};
      if (frame_ev)
      begin
        st_nxt.bit_cnt   = 4'h0;
        st_nxt.out_valid = 1'b0;
      end
      else
      begin
        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
      end
    end

    if (do_dec)
    begin
      st_nxt.prev_ins = ins;
      case (ins)
        INS_LOAD_CMD:
          st_nxt.cmd = dbyte;
        INS_ADDR_LO:
          st_nxt.addr_lo = dbyte;
        INS_ADDR_HI:
          st_nxt.addr_hi = dbyte;
        INS_DATA_LO:
          st_nxt.data_lo = dbyte;
        INS_DATA_HI:
          st_nxt.data_hi = dbyte;
        INS_LATCH_FLASH:
          if (st_r.cmd == CMD_WR_FLASH)
          begin
            fb_if.we = 1'b1;
            st_nxt.fmask[st_r.addr_lo[FLASH_PW-1:0]] = 1'b1;
          end
        INS_LATCH_EE:
          if (st_r.cmd == CMD_WR_EE)
          begin
            eb_if.we = 1'b1;
            st_nxt.emask[st_r.addr_lo[EE_PW-1:0]] = 1'b1;
          end
        INS_RD_LO_EN:
          if (st_r.cmd == CMD_RD_FLASH)
          begin
            st_nxt.out_sh    = {fl_if.rdata[7:0], 3'h0};
            st_nxt.out_valid = 1'b1;
          end
          else if (st_r.cmd == CMD_RD_EE)
          begin
            st_nxt.out_sh    = {ee_if.rdata, 3'h0};
            st_nxt.out_valid = 1'b1;
          end
        INS_RD_HI_EN:
          if (st_r.cmd == CMD_RD_FLASH)
          begin
            st_nxt.out_sh    = {fl_if.rdata[15:8], 3'h0};
            st_nxt.out_valid = 1'b1;
          end
        INS_PROG_B:
          if (st_r.prev_ins == INS_PROG_A)
          begin
            st_nxt.idx = 16'h0000;
            if (st_r.cmd == CMD_ERASE)
            begin
              st_nxt.mode     = ST_ERASE;
              st_nxt.erase_ee = 1'b0;
              st_nxt.keep     = keep_eeprom_on_erase_in;
            end
            else if (st_r.cmd == CMD_WR_FLASH || st_r.cmd == CMD_WR_EE)
            begin
              st_nxt.mode = ST_PROG;
            end
          end
        default:
          st_nxt.prev_ins = ins;
      endcase
    end

    case (st_r.mode)
      ST_OFF:
        if (st_r.hv_q2)
        begin
          st_nxt.mode = ST_LATCH;
          st_nxt.cnt  = 8'h00;
        end
      ST_LATCH:
      begin
        st_nxt.cnt = st_r.cnt + 8'h01;
        if (st_r.cnt == HV_LATCH_CNT)
        begin
          if ({st_r.sdop_q2, st_r.sii_q2, st_r.sdi_q2} == ENTRY_PATTERN)
          begin
            st_nxt.mode    = ST_READY;
            st_nxt.linked  = 1'b1;
            st_nxt.oe      = 1'b1;
            st_nxt.bit_cnt = 4'h0;
            st_nxt.lock    = lock_bits_in;
          end
          else
          begin
            st_nxt.mode = ST_REJECT;
          end
        end
      end
      ST_ERASE:
        if (!st_r.erase_ee)
        begin
          fl_if.we    = 1'b1;
          fl_if.waddr = st_r.idx[FLASH_AW-1:0];
          st_nxt.idx  = st_r.idx + 16'h0001;
          if (st_r.idx == FLASH_LAST)
          begin
            st_nxt.idx      = 16'h0000;
            st_nxt.erase_ee = 1'b1;
            if (st_r.keep)
            begin
              st_nxt.mode = ST_READY;
              st_nxt.lock = LOCK_ERASED;
            end
          end
        end
        else
        begin
          ee_if.we    = 1'b1;
          ee_if.waddr = st_r.idx[EE_AW-1:0];
          st_nxt.idx  = st_r.idx + 16'h0001;
          if (st_r.idx == EE_LAST)
          begin
            st_nxt.mode = ST_READY;
            st_nxt.lock = LOCK_ERASED;
          end
        end
      ST_PROG:
      begin
        // Buffer read has one cycle of latency, so each write trails idx
        st_nxt.idx = st_r.idx + 16'h0001;
        if (st_r.cmd == CMD_WR_FLASH)
        begin
          if (st_r.idx != 16'h0000 && st_r.fmask[slot[FLASH_PW-1:0]])
          begin
            fl_if.we    = 1'b1;
            fl_if.waddr = {addr_w[FLASH_AW-1:FLASH_PW], slot[FLASH_PW-1:0]};
            fl_if.wdata = fb_if.rdata;
          end
          if (st_r.idx == FPAGE_END)
          begin
            st_nxt.mode  = ST_READY;
            st_nxt.fmask = '0;
          end
        end
        else
        begin
          if (st_r.idx != 16'h0000 && st_r.emask[slot[EE_PW-1:0]])
          begin
            ee_if.we    = 1'b1;
            ee_if.waddr = {addr_w[EE_AW-1:EE_PW], slot[EE_PW-1:0]};
            ee_if.wdata = eb_if.rdata;
          end
          if (st_r.idx == EPAGE_END)
          begin
            st_nxt.mode  = ST_READY;
            st_nxt.emask = '0;
          end
        end
      end
      default:
        st_nxt.cnt = st_r.cnt;
    endcase

    // Losing the high voltage drops the session, command, address and page masks; loaded data bytes are kept
    if (!st_r.hv_q2 && st_r.mode != ST_OFF)
    begin
      st_nxt.mode      = ST_OFF;
      st_nxt.linked    = 1'b0;
      st_nxt.oe        = 1'b0;
      st_nxt.cmd       = CMD_NOP;
      st_nxt.addr_lo   = 8'h00;
      st_nxt.addr_hi   = 8'h00;
      st_nxt.fmask     = '0;
      st_nxt.emask     = '0;
      st_nxt.out_valid = 1'b0;
    end

    st_nxt.busy = (st_nxt.mode == ST_ERASE) || (st_nxt.mode == ST_PROG);
    if (!st_nxt.linked || st_nxt.busy)
      st_nxt.serial_data_out = 1'b0;
    else if (st_nxt.out_valid)
      st_nxt.serial_data_out = st_nxt.out_sh[10];
    else
      st_nxt.serial_data_out = 1'b1;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign serial_data_out_out    = st_r.serial_data_out;
  assign serial_data_out_oe_out = st_r.oe;
  assign prog_mode_out          = st_r.linked;
  assign busy_out               = st_r.busy;
  assign lock_bits_out          = st_r.lock;

  property p_entry;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st_r.mode == ST_LATCH && st_r.cnt == HV_LATCH_CNT && st_r.hv_q2
      && {st_r.sdop_q2, st_r.sii_q2, st_r.sdi_q2} == ENTRY_PATTERN)
      |=> (st_r.mode == ST_READY) ##1 (serial_data_out_oe_out && serial_data_out_out);
  endproperty
  a_entry: assert property (p_entry) else $error("entry pattern not accepted");

  property p_exit;
    @(posedge clk_sys_in) disable iff (rst_in)
    (!st_r.hv_q2 && st_r.linked) |=> (!prog_mode_out && !serial_data_out_oe_out);
  endproperty
  a_exit: assert property (p_exit) else $error("mode kept without high voltage");

  property p_cmd_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st_r.hv_q2 && !(do_dec && ins == INS_LOAD_CMD)) |=> $stable(st_r.cmd);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command changed unloaded");

  property p_hi_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st_r.hv_q2 && !(do_dec && ins == INS_ADDR_HI)) |=> $stable(st_r.addr_hi);
  endproperty
  a_hi_hold: assert property (p_hi_hold) else $error("high address changed unloaded");

  property p_erase_flash_first;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st_r.mode == ST_ERASE && !st_r.erase_ee)
      |-> (fl_if.we && fl_if.wdata == 16'hffff && !ee_if.we);
  endproperty
  a_erase_flash_first: assert property (p_erase_flash_first) else $error("erase order");

  // With keep set, the last flash write and lock reset share one edge, so only earlier steps must hold the lock
  property p_lock_hold;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st_r.mode == ST_ERASE && !st_r.erase_ee && st_r.idx != FLASH_LAST)
      |=> $stable(lock_bits_out);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock reset before flash erased");

  property p_keep_ee;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st_r.mode == ST_ERASE && st_r.keep) |-> !ee_if.we;
  endproperty
  a_keep_ee: assert property (p_keep_ee) else $error("EEPROM written under keep fuse");

  property p_flash_start;
    @(posedge clk_sys_in) disable iff (rst_in)
    (do_dec && st_r.hv_q2 && ins == INS_PROG_B && st_r.prev_ins == INS_PROG_A
      && st_r.cmd == CMD_WR_FLASH) |=> (st_r.mode == ST_PROG) [*2] ##0 !serial_data_out_out;
  endproperty
  a_flash_start: assert property (p_flash_start) else $error("page program not started");

  property p_busy_low;
    @(posedge clk_sys_in) disable iff (rst_in)
    ((st_r.mode == ST_ERASE || st_r.mode == ST_PROG) && st_r.hv_q2)
      |-> (!serial_data_out_out && busy_out);
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("data out not low while busy");

  property p_done_high;
    @(posedge clk_sys_in) disable iff (rst_in)
    ($past(st_r.mode) == ST_PROG && st_r.mode == ST_READY && !st_r.out_valid)
      |-> serial_data_out_out;
  endproperty
  a_done_high: assert property (p_done_high) else $error("data out not high when done");

  property p_read_lo;
    @(posedge clk_sys_in) disable iff (rst_in)
    (do_dec && st_r.hv_q2 && ins == INS_RD_LO_EN && st_r.cmd == CMD_RD_FLASH)
      |=> (st_r.out_sh[10:3] == $past(fl_if.rdata[7:0])) ##1 (busy_out == 1'b0);
  endproperty
  a_read_lo: assert property (p_read_lo) else $error("flash low byte not loaded");

  property p_read_ee;
    @(posedge clk_sys_in) disable iff (rst_in)
    (do_dec && st_r.hv_q2 && ins == INS_RD_LO_EN && st_r.cmd == CMD_RD_EE)
      |=> (st_r.out_valid && st_r.out_sh[10:3] == $past(ee_if.rdata));
  endproperty
  a_read_ee: assert property (p_read_ee) else $error("EEPROM byte not loaded");

  property p_rise_shift;
    @(posedge clk_sys_in) disable iff (rst_in)
    (st_r.linked && st_r.hv_q2 && sci_rise && st_r.bit_cnt != FRAME_LAST)
      |=> (st_r.bit_cnt == $past(st_r.bit_cnt) + 4'h1);
  endproperty
  a_rise_shift: assert property (p_rise_shift) else $error("bit not taken on rising edge");

  property p_wr_flash_cmd;
    @(posedge clk_sys_in) disable iff (rst_in)
    (do_dec && st_r.hv_q2 && sii_frame == 11'h130 && sdi_frame == 11'h040)
      |=> st_r.cmd == CMD_WR_FLASH;
  endproperty
  a_wr_flash_cmd: assert property (p_wr_flash_cmd) else $error("write command missed");

endmodule // hvsp_seq

// *** tb/hv_programmer.sv ***
`timescale 1ns/10ps
module hv_programmer (
  // Clock
  input  wire logic clk_in,
  // Device side of the data out pin
  input  wire logic dev_dout_in,
  input  wire logic dev_oe_in,
  // Programming pins
  output logic      hv_out,
  output logic      ser_clk_out,
  output logic      ser_data_out,
  output logic      ser_instr_out,
  output logic      pin_dout_out
);
  logic drv_r;
  logic val_r;
  logic flt_r;

  // Released pin has no pull: show a toggling level so a stale value never passes
  always @(posedge clk_in)
    flt_r <= ~flt_r;
  assign pin_dout_out = dev_oe_in ? dev_dout_in : (drv_r ? val_r : flt_r);

  initial
  begin
    hv_out = 1'b0;
    ser_clk_out = 1'b0;
    ser_data_out = 1'b0;
    ser_instr_out = 1'b0;
    drv_r = 1'b1;
    val_r = 1'b0;
    flt_r = 1'b0;
  end

  task automatic enter(input logic [2:0] pat);
    @(posedge clk_in);
    ser_data_out <= pat[0];
    ser_instr_out <= pat[1];
    val_r <= pat[2];
    drv_r <= 1'b1;
    repeat (2) @(posedge clk_in);
    hv_out <= 1'b1;
    repeat (100) @(posedge clk_in);
    drv_r <= 1'b0;
    repeat (3000) @(posedge clk_in);
  endtask

  task automatic leave();
    @(posedge clk_in);
    hv_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  // Serial clock stands low between frames; 8 clk period is above the minimum
  task automatic xfer(input logic [7:0] d, input logic [7:0] i, output logic [7:0] q);
    logic [10:0] fd;
    logic [10:0] fi;
    fd = {1'b0, d, 2'b00};
    fi = {1'b0, i, 2'b00};
    q = 8'h00;
    for (int b = 10; b >= 0; b--)
    begin
      @(posedge clk_in);
      ser_clk_out <= 1'b0;
      ser_data_out <= fd[b];
      ser_instr_out <= fi[b];
      repeat (4) @(posedge clk_in);
      ser_clk_out <= 1'b1;
      if (b >= 3)
        q[b-3] = pin_dout_out;
      repeat (3) @(posedge clk_in);
    end
    @(posedge clk_in);
    ser_clk_out <= 1'b0;
  endtask
endmodule // hv_programmer

// *** tb/testbench.sv ***
`timescale 1ns/10ps
module testbench;
  import hvsp_pkg::*;
  logic        clk_sys_in;
  logic        rst_in;
  logic        hv;
  logic        ser_clk;
  logic        ser_data;
  logic        ser_instr;
  logic        pin_dout;
  logic        dev_dout;
  logic        dev_oe;
  logic        keep_fuse;
  logic [7:0]  lock_in;
  logic        prog_mode;
  logic        busy;
  logic [7:0]  lock_out;
  logic [15:0] words [2];
  int          n_fail;
  int          num_checks;
  int          cyc;

  hvsp_seq #(.FLASH_AW(6)) dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .hv_reset_in(hv),
    .serial_clock_in(ser_clk), .serial_data_in(ser_data), .serial_instr_in(ser_instr),
    .serial_data_out_in(pin_dout), .serial_data_out_out(dev_dout),
    .serial_data_out_oe_out(dev_oe), .keep_eeprom_on_erase_in(keep_fuse),
    .lock_bits_in(lock_in), .prog_mode_out(prog_mode), .busy_out(busy),
    .lock_bits_out(lock_out));

  hv_programmer prog (
    .clk_in(clk_sys_in), .dev_dout_in(dev_dout), .dev_oe_in(dev_oe), .hv_out(hv),
    .ser_clk_out(ser_clk), .ser_data_out(ser_data), .ser_instr_out(ser_instr),
    .pin_dout_out(pin_dout));

  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Runaway guard; the full sequence needs about 12250 cycles
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  task automatic f(input logic [7:0] d, input logic [7:0] i);
    logic [7:0] q;
    prog.xfer(d, i, q);
  endtask

  task automatic cmd(input logic [7:0] c);
    f(c, INS_LOAD_CMD);
  endtask

  task automatic rd(input logic [7:0] ld, input logic [7:0] sh, input logic [7:0] exp);
    logic [7:0] q;
    f(8'h00, ld);
    prog.xfer(8'h00, sh, q);
    chk({8'h00, q}, {8'h00, exp}, "read byte");
  endtask

  // Busy shows as a low data out that must return high within a bounded time
  task automatic wait_ready();
    int n;
    n = 0;
    repeat (3) @(posedge clk_sys_in);
    chk({14'h0, busy, pin_dout}, 16'h2, "busy level");
    while (pin_dout !== 1'b1 && n < 3000)
    begin
      @(posedge clk_sys_in);
      n++;
    end
    chk({14'h0, busy, pin_dout}, 16'h1, "ready level");
  endtask

  task automatic erase(input logic [7:0] lk);
    cmd(CMD_ERASE);
    f(8'h00, INS_PROG_A);
    f(8'h00, INS_PROG_B);
    repeat (3) @(posedge clk_sys_in);
    chk({8'h00, lock_out}, {8'h00, lk}, "lock before sweep end");
    wait_ready();
    chk({8'h00, lock_out}, {8'h00, LOCK_ERASED}, "lock after erase");
    cmd(CMD_NOP);
  endtask

  initial
  begin
    rst_in = 1'b1;
    keep_fuse = 1'b0;
    lock_in = 8'h3c;
    words = '{16'ha55a, 16'h0ff0};
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    prog.enter(3'b001);
    chk({15'h0, prog_mode}, 16'h0, "wrong pattern refused");
    prog.leave();
    prog.enter(ENTRY_PATTERN);
    chk({14'h0, dev_oe, prog_mode}, 16'h3, "entry");
    erase(8'h3c);
    cmd(CMD_RD_FLASH);
    f(8'h00, INS_ADDR_HI);
    f(8'h03, INS_ADDR_LO);
    rd(INS_RD_LO_EN, INS_PROG_B, 8'hff);
    cmd(CMD_WR_FLASH);
    for (int k = 0; k < 2; k++)
    begin
      f(8'(3 + k), INS_ADDR_LO);
      f(words[k][7:0], INS_DATA_LO);
      f(words[k][15:8], INS_DATA_HI);
      f(8'h00, INS_LATCH_FLASH);
    end
    f(8'h00, INS_ADDR_HI);
    f(8'h00, INS_PROG_A);
    f(8'h00, INS_PROG_B);
    wait_ready();
    cmd(CMD_NOP);
    cmd(CMD_RD_FLASH);
    f(8'h00, INS_ADDR_HI);
    for (int k = 0; k < 2; k++)
    begin
      f(8'(3 + k), INS_ADDR_LO);
      rd(INS_RD_LO_EN, INS_PROG_B, words[k][7:0]);
      rd(INS_RD_HI_EN, 8'h7c, words[k][15:8]);
    end
    cmd(CMD_WR_EE);
    f(8'h05, INS_ADDR_LO);
    f(8'h01, INS_ADDR_HI);
    f(8'hc3, INS_DATA_LO);
    f(8'h00, INS_LATCH_EE);
    f(8'h00, INS_PROG_A);
    f(8'h00, INS_PROG_B);
    wait_ready();
    cmd(CMD_NOP);
    cmd(CMD_RD_EE);
    f(8'h05, INS_ADDR_LO);
    f(8'h01, INS_ADDR_HI);
    rd(INS_RD_LO_EN, INS_PROG_B, 8'hc3);
    keep_fuse <= 1'b1;
    erase(8'hff);
    cmd(CMD_RD_EE);
    f(8'h05, INS_ADDR_LO);
    rd(INS_RD_LO_EN, INS_PROG_B, 8'hc3);
    cmd(CMD_RD_FLASH);
    f(8'h00, INS_ADDR_HI);
    f(8'h04, INS_ADDR_LO);
    rd(INS_RD_HI_EN, 8'h7c, 8'hff);
    prog.leave();
    chk({14'h0, dev_oe, prog_mode}, 16'h0, "exit");
    finish_test();
  end
endmodule // testbench
